/* File: logic/vtf_pkg.sv */
package vtf_pkg;
  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [3:0]  OFF_IO_PROC_DIS = 4'h0;
  localparam logic [3:0]  OFF_STATUS      = 4'h4;
  localparam int          BIT_H_CONFIG    = 0;
  localparam logic        H_CONFIG_RST    = 1'b0;
  localparam int          ST_LOCK         = 0;
  localparam int          ST_CARRIER_OK   = 1;
  localparam int          ST_LOOP_EN      = 2;
  localparam int          ST_TEST_MODE    = 3;
  localparam int          ST_H            = 4;
  localparam int          ST_V            = 5;
  localparam int          ST_F            = 6;
  localparam logic [1:0]  RESP_OKAY       = 2'h0;
  localparam logic [1:0]  RESP_DECERR     = 2'h3;

  // ----------------------------------------------------------------
  // TRS words and layout
  // ----------------------------------------------------------------
  localparam logic [9:0]  TRS_WORD0       = 10'h3ff;
  localparam logic [9:0]  TRS_WORD12      = 10'h000;
  localparam int          TRS_LEN         = 4;
  localparam int          XYZ_F_POS       = 8;
  localparam int          XYZ_V_POS       = 7;
  localparam int          XYZ_H_POS       = 6;
  localparam logic [1:0]  SAV_TAIL_CNT    = 2'h3;

  // ----------------------------------------------------------------
  // Pin synchronisers: count, slots and reset values
  // ----------------------------------------------------------------
  localparam int          NUM_ASYNC       = 3;
  localparam int          SYN_CARRIER     = 0;
  localparam int          SYN_LOOP_EN     = 1;
  localparam int          SYN_TEST_SEL    = 2;
  localparam logic [2:0]  SYNC_RST        = 3'h1;
endpackage

/* File: logic/vtf_trs_if.sv */
`timescale 1ns/100ps
interface vtf_trs_if #(parameter int WIDTH = 10);
  logic [WIDTH-1:0] word_dly;
  logic             trs_start;
  logic             f_bit;
  logic             v_bit;
  logic             h_bit;

  modport prod (output word_dly, trs_start, f_bit, v_bit, h_bit);
  modport cons (input  word_dly, trs_start, f_bit, v_bit, h_bit);
endinterface

/* File: logic/vtf_trs_detect.sv */
`timescale 1ns/100ps
module vtf_trs_detect #(
  parameter int WIDTH = 10
) (
  input  wire logic             aclk,
  input  wire logic             aresetn,
  input  wire logic [WIDTH-1:0] pix_word,
  vtf_trs_if.prod               trs
);
  // ----------------------------------------------------------------
  // Four word delay line
  // ----------------------------------------------------------------
  logic [WIDTH-1:0] pipe_reg [vtf_pkg::TRS_LEN];

  // Stage 0 loads the new word, later stages age it
  genvar gi;
  generate
    for (gi = 0; gi < vtf_pkg::TRS_LEN; gi++) begin : g_pipe
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          pipe_reg[gi] <= '0;
        end else if (gi == 0) begin
          pipe_reg[gi] <= pix_word;
        end else begin
          pipe_reg[gi] <= pipe_reg[gi-1];
        end
      end
    end
  endgenerate

  // Oldest word is the first TRS word when the whole pattern is held
  assign trs.word_dly  = pipe_reg[3];
  assign trs.trs_start = (pipe_reg[3] == vtf_pkg::TRS_WORD0)
                      && (pipe_reg[2] == vtf_pkg::TRS_WORD12)
                      && (pipe_reg[1] == vtf_pkg::TRS_WORD12);
  assign trs.f_bit     = pipe_reg[0][vtf_pkg::XYZ_F_POS];
  assign trs.v_bit     = pipe_reg[0][vtf_pkg::XYZ_V_POS];
  assign trs.h_bit     = pipe_reg[0][vtf_pkg::XYZ_H_POS];
endmodule

/* File: logic/vtf_top.sv */
`timescale 1ns/100ps
module vtf_top #(
  parameter int WIDTH = 10
) (
  input  wire logic             aclk,
  input  wire logic             aresetn,
  // AXI4-Lite slave
  input  wire logic [3:0]       s_axi_awaddr,
  input  wire logic             s_axi_awvalid,
  output wire logic             s_axi_awready,
  input  wire logic [31:0]      s_axi_wdata,
  input  wire logic [3:0]       s_axi_wstrb,
  input  wire logic             s_axi_wvalid,
  output wire logic             s_axi_wready,
  output wire logic [1:0]       s_axi_bresp,
  output wire logic             s_axi_bvalid,
  input  wire logic             s_axi_bready,
  input  wire logic [3:0]       s_axi_araddr,
  input  wire logic             s_axi_arvalid,
  output wire logic             s_axi_arready,
  output wire logic [31:0]      s_axi_rdata,
  output wire logic [1:0]       s_axi_rresp,
  output wire logic             s_axi_rvalid,
  input  wire logic             s_axi_rready,
  // Video path from the deserializer core
  input  wire logic [WIDTH-1:0] pix_word,
  input  wire logic             core_lock_indication,
  output wire logic [WIDTH-1:0] pix_out,
  output wire logic             h_flag,
  output wire logic             v_flag,
  output wire logic             f_flag,
  output wire logic             lock_indication,
  // Asynchronous control pins
  input  wire logic             carrier_detect_input2,
  input  wire logic             loop_output_enable,
  input  wire logic             test_host_select,
  output wire logic             loop_drive_en,
  output wire logic             loop_serial_output_oe_n,
  // Shared host port / JTAG pins
  input  wire logic             cs_tms_pin,
  input  wire logic             sclk_tck_pin,
  input  wire logic             shared_serial_in_pin,
  output wire logic             shared_serial_out_pin,
  output wire logic             shared_serial_out_oe_n,
  // Host serial port side
  output wire logic             host_cs_n,
  output wire logic             host_sclk,
  output wire logic             host_serial_in,
  input  wire logic             host_serial_out,
  input  wire logic             host_serial_out_en,
  // JTAG side
  output wire logic             jtag_tms,
  output wire logic             jtag_tck,
  output wire logic             jtag_tdi,
  input  wire logic             jtag_tdo,
  input  wire logic             jtag_tdo_en
);
  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic              h_config_reg;
  logic              aw_full_reg;
  logic [3:0]        aw_addr_reg;
  logic              w_full_reg;
  logic [31:0]       w_data_reg;
  logic              w_strb0_reg;
  logic              bvalid_reg;
  logic [1:0]        bresp_reg;
  logic              rvalid_reg;
  logic [31:0]       rdata_reg;
  logic [1:0]        rresp_reg;
  logic [2:0]        sync_reg   [vtf_pkg::NUM_ASYNC];
  logic              stable_reg [vtf_pkg::NUM_ASYNC];
  logic              h_flag_reg;
  logic              h_flag_next;
  logic              h_bit_reg;
  logic              v_flag_reg;
  logic              f_flag_reg;
  logic [1:0]        sav_cnt_reg;
  logic [1:0]        sav_cnt_next;
  logic [WIDTH-1:0]  pix_out_reg;
  logic              lock_reg;

  vtf_trs_if #(.WIDTH(WIDTH)) trs ();

  // ----------------------------------------------------------------
  // TRS detection
  // ----------------------------------------------------------------
  vtf_trs_detect #(.WIDTH(WIDTH)) u_trs (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .pix_word (pix_word),
    .trs      (trs)
  );

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  wire logic [vtf_pkg::NUM_ASYNC-1:0] pin_raw;
  assign pin_raw[vtf_pkg::SYN_CARRIER]  = carrier_detect_input2;
  assign pin_raw[vtf_pkg::SYN_LOOP_EN]  = loop_output_enable;
  assign pin_raw[vtf_pkg::SYN_TEST_SEL] = test_host_select;

  // Three stages; a change counts once stages two and three agree
  genvar gi;
  generate
    for (gi = 0; gi < vtf_pkg::NUM_ASYNC; gi++) begin : g_sync
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          sync_reg[gi]   <= {3{vtf_pkg::SYNC_RST[gi]}};
          stable_reg[gi] <= vtf_pkg::SYNC_RST[gi];
        end else begin
          sync_reg[gi]   <= {sync_reg[gi][1:0], pin_raw[gi]};
          if (sync_reg[gi][1] == sync_reg[gi][2]) begin
            stable_reg[gi] <= sync_reg[gi][2];
          end
        end
      end
    end
  endgenerate

  wire logic carrier_ok = !stable_reg[vtf_pkg::SYN_CARRIER];
  wire logic loop_en    = stable_reg[vtf_pkg::SYN_LOOP_EN];
  wire logic test_mode  = stable_reg[vtf_pkg::SYN_TEST_SEL];

  // ----------------------------------------------------------------
  // Loop-through output enable
  // ----------------------------------------------------------------
  // drive only when enabled
  assign loop_drive_en           = loop_en;
  assign loop_serial_output_oe_n = !loop_en;

  // ----------------------------------------------------------------
  // Shared pin routing
  // ----------------------------------------------------------------
  // serial input steering
  assign host_serial_in = test_mode ? 1'b1 : shared_serial_in_pin;
  assign jtag_tdi       = test_mode ? shared_serial_in_pin : 1'b1;
  assign host_cs_n      = test_mode ? 1'b1 : cs_tms_pin;
  assign host_sclk      = test_mode ? 1'b1 : sclk_tck_pin;
  assign jtag_tms       = test_mode ? cs_tms_pin : 1'b1;
  assign jtag_tck       = test_mode ? sclk_tck_pin : 1'b1;
  assign shared_serial_out_pin  = test_mode ? jtag_tdo : host_serial_out;
  assign shared_serial_out_oe_n = test_mode ? !jtag_tdo_en
                                            : !host_serial_out_en;

  // ----------------------------------------------------------------
  // Timing flags
  // ----------------------------------------------------------------
  // Latched H bit, updated at each TRS
  wire logic h_bit_next = trs.trs_start ? trs.h_bit : h_bit_reg;
  wire logic sav_start  = trs.trs_start && !trs.h_bit;

  // hold high through the four SAV words
  assign sav_cnt_next = sav_start ? vtf_pkg::SAV_TAIL_CNT
                      : (sav_cnt_reg != 2'h0) ? sav_cnt_reg - 2'h1
                      : 2'h0;
  // TRS based mode follows the H bit alone
  assign h_flag_next  = h_config_reg ? h_bit_next
                      : (h_bit_next || trs.trs_start
                         || (sav_cnt_reg != 2'h0));

  // flags registered with the word they describe
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      h_bit_reg   <= 1'b0;
      h_flag_reg  <= 1'b0;
      sav_cnt_reg <= 2'h0;
    end else begin
      h_bit_reg   <= h_bit_next;
      h_flag_reg  <= h_flag_next;
      sav_cnt_reg <= sav_cnt_next;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      v_flag_reg <= 1'b0;
      f_flag_reg <= 1'b0;
    end else if (trs.trs_start) begin
      v_flag_reg <= trs.v_bit;
      f_flag_reg <= trs.f_bit;
    end
  end

  // ----------------------------------------------------------------
  // Parallel output and lock
  // ----------------------------------------------------------------
  // mute data and drop lock without carrier
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pix_out_reg <= '0;
      lock_reg    <= 1'b0;
    end else begin
      pix_out_reg <= carrier_ok ? trs.word_dly : '0;
      lock_reg    <= carrier_ok && core_lock_indication;
    end
  end

  assign pix_out         = pix_out_reg;
  assign h_flag          = h_flag_reg;
  assign v_flag          = v_flag_reg;
  assign f_flag          = f_flag_reg;
  assign lock_indication = lock_reg;

  // ----------------------------------------------------------------
  // AXI4-Lite write path
  // ----------------------------------------------------------------
  wire logic aw_take  = s_axi_awvalid && !aw_full_reg;
  wire logic w_take   = s_axi_wvalid && !w_full_reg;
  wire logic wr_fire  = aw_full_reg && w_full_reg && !bvalid_reg;
  wire logic wr_cfg   = aw_addr_reg == vtf_pkg::OFF_IO_PROC_DIS;
  wire logic wr_known = wr_cfg || (aw_addr_reg == vtf_pkg::OFF_STATUS);

  assign s_axi_awready = !aw_full_reg;
  assign s_axi_wready  = !w_full_reg;
  assign s_axi_bvalid  = bvalid_reg;
  assign s_axi_bresp   = bresp_reg;

  // Address and data are captured in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_reg <= 1'b0;
      aw_addr_reg <= 4'h0;
    end else if (aw_take) begin
      aw_full_reg <= 1'b1;
      aw_addr_reg <= {s_axi_awaddr[3:2], 2'h0};
    end else if (wr_fire) begin
      aw_full_reg <= 1'b0;
    end
  end

  // Write data holding stage
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_full_reg  <= 1'b0;
      w_data_reg  <= 32'h0;
      w_strb0_reg <= 1'b0;
    end else if (w_take) begin
      w_full_reg  <= 1'b1;
      w_data_reg  <= s_axi_wdata;
      w_strb0_reg <= s_axi_wstrb[0];
    end else if (wr_fire) begin
      w_full_reg  <= 1'b0;
    end
  end

  // flag select held in the processing disable register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      h_config_reg <= vtf_pkg::H_CONFIG_RST;
    end else if (wr_fire && wr_cfg && w_strb0_reg) begin
      h_config_reg <= w_data_reg[vtf_pkg::BIT_H_CONFIG];
    end
  end

  // Write response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_reg <= 1'b0;
      bresp_reg  <= vtf_pkg::RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_reg <= 1'b1;
      bresp_reg  <= wr_known ? vtf_pkg::RESP_OKAY : vtf_pkg::RESP_DECERR;
    end else if (s_axi_bready) begin
      bvalid_reg <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite read path
  // ----------------------------------------------------------------
  wire logic [3:0]  rd_addr  = {s_axi_araddr[3:2], 2'h0};
  wire logic        ar_take  = s_axi_arvalid && !rvalid_reg;
  wire logic        rd_cfg   = rd_addr == vtf_pkg::OFF_IO_PROC_DIS;
  wire logic        rd_stat  = rd_addr == vtf_pkg::OFF_STATUS;
  wire logic [31:0] cfg_word = {31'h0, h_config_reg};
  wire logic [31:0] stat_word;
  assign stat_word = {25'h0, f_flag_reg, v_flag_reg, h_flag_reg,
                      test_mode, loop_en, carrier_ok, lock_reg};
  wire logic [31:0] rd_word  = rd_cfg  ? cfg_word
                             : rd_stat ? stat_word : 32'h0;

  assign s_axi_arready = !rvalid_reg;
  assign s_axi_rvalid  = rvalid_reg;
  assign s_axi_rdata   = rdata_reg;
  assign s_axi_rresp   = rresp_reg;

  // Read answer one cycle after the address is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_reg <= 1'b0;
      rdata_reg  <= 32'h0;
      rresp_reg  <= vtf_pkg::RESP_OKAY;
    end else if (ar_take) begin
      rvalid_reg <= 1'b1;
      rdata_reg  <= rd_word;
      rresp_reg  <= (rd_cfg || rd_stat) ? vtf_pkg::RESP_OKAY
                                        : vtf_pkg::RESP_DECERR;
    end else if (s_axi_rready) begin
      rvalid_reg <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence sav_seen;
    !h_config_reg && sav_start;
  endsequence

  sequence sav_hold;
    (h_flag_reg || h_config_reg) [*4];
  endsequence

  sav_blank_a: assert property (sav_seen |=> sav_hold)
    else $error("Horizontal flag fell inside SAV");
  h_trs_mode_a: assert property (
    h_config_reg && trs.trs_start |=> h_flag_reg == $past(trs.h_bit))
    else $error("Horizontal flag not following H bit");
  cfg_write_a: assert property (
    $changed(h_config_reg) |-> $rose(bvalid_reg))
    else $error("Flag select changed without a write");
  carrier_ok_a: assert property (
    carrier_ok && core_lock_indication |=> lock_reg)
    else $error("Lock missing with valid carrier");
  carrier_mute_a: assert property (
    !carrier_ok |=> !lock_reg && pix_out_reg == '0)
    else $error("Output not muted without carrier");
  loop_oe_a: assert property (
    loop_serial_output_oe_n == !loop_drive_en and ($changed(loop_drive_en)
    |-> loop_drive_en == $past(sync_reg[vtf_pkg::SYN_LOOP_EN][2])))
    else $error("Loop output enable mismatch");
  tdi_route_a: assert property (
    test_mode |-> jtag_tdi == shared_serial_in_pin && host_serial_in)
    else $error("Serial input misrouted");
  v_bit_a: assert property (
    trs.trs_start |=> v_flag_reg == $past(trs.v_bit))
    else $error("Vertical flag not following V bit");
  f_bit_a: assert property (
    trs.trs_start |=> f_flag_reg == $past(trs.f_bit))
    else $error("Field flag not following F bit");
  host_route_a: assert property (
    !test_mode |-> host_cs_n == cs_tms_pin && jtag_tck)
    else $error("Host pins misrouted");
  flag_hold_a: assert property (
    !trs.trs_start |=> $stable(v_flag_reg) && $stable(f_flag_reg))
    else $error("Timing flag moved without TRS");
endmodule

/* File: dv/vtf_video_src.sv */
`timescale 1ns/100ps
// ------------------------------------------------------------------
// Video source and cable equalizer model
// ------------------------------------------------------------------
module vtf_video_src (
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic       field_two,
  input  wire logic       vert_blank,
  input  wire logic       signal_ok,
  output wire logic [9:0] pix_word,
  output logic      [3:0] pos,
  output logic            line_f,
  output logic            line_v,
  output logic            carrier_detect_input2
);
  wire logic       h_bit;
  wire logic [9:0] xyz;

  // ID word of each TRS, H set only in the EAV half of the line
  assign h_bit = (pos < 4'h8);
  assign xyz = {1'h1, line_f, line_v, h_bit, line_v ^ h_bit,
                line_f ^ h_bit, line_f ^ line_v,
                line_f ^ line_v ^ h_bit, 2'h0};
  // Sixteen words a line: EAV, blanking, SAV, active picture
  assign pix_word = pos[2] ? (pos[3] ? 10'h040 + {6'h0, pos} : 10'h200) :
                    (pos[1:0] == 2'h0) ? 10'h3ff :
                    (pos[1:0] == 2'h3) ? xyz : 10'h000;

  // Word position counter, field and blanking taken once a line
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pos    <= 4'h0;
      line_f <= 1'h0;
      line_v <= 1'h0;
    end else begin
      pos <= pos + 4'h1;
      if (pos == 4'hf) begin
        line_f <= field_two;
        line_v <= vert_blank;
      end
    end
  end

  // equalizer pulls low while signal present
  always_ff @(posedge aclk) begin
    carrier_detect_input2 <= !signal_ok;
  end
endmodule

/* File: dv/vtf_top_bench.sv */
`timescale 1ns/100ps
module vtf_top_bench;
  // ----------------------------------------------------------------
  // Stimulus and observed signals
  // ----------------------------------------------------------------
  localparam int PIPE    = 5;
  localparam int TIMEOUT = 20000;
  logic        aclk = 1'h0, aresetn = 1'h0, core_lock_indication = 1'h1;
  logic [3:0]  s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hf;
  logic [31:0] s_axi_wdata = 32'h0;
  logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic        s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic        loop_output_enable = 1'h0, test_host_select = 1'h0;
  logic        cs_tms_pin = 1'h1, sclk_tck_pin = 1'h1;
  logic        shared_serial_in_pin = 1'h1, host_serial_out = 1'h0;
  logic        host_serial_out_en = 1'h0, jtag_tdo = 1'h0, jtag_tdo_en = 1'h0;
  logic        field_two = 1'h0, vert_blank = 1'h0, signal_ok = 1'h1;
  wire logic   s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  wire logic   s_axi_rvalid, h_flag, v_flag, f_flag, lock_indication;
  wire logic   loop_drive_en, loop_serial_output_oe_n, shared_serial_out_pin;
  wire logic   shared_serial_out_oe_n, host_cs_n, host_sclk, host_serial_in;
  wire logic   jtag_tms, jtag_tck, jtag_tdi, line_f, line_v;
  wire logic   carrier_detect_input2;
  wire logic [1:0]  s_axi_bresp, s_axi_rresp;
  wire logic [31:0] s_axi_rdata;
  wire logic [9:0]  pix_out, pix_word;
  wire logic [3:0]  pos;
  logic [15:0] hist [0:PIPE];
  logic        vid_on = 1'h0, pix_on = 1'h0, muted = 1'h0, h_mode = 1'h0;
  logic        exp_f = 1'h0, exp_v = 1'h0;
  int          failures = 0, check_count = 0, cycles = 0;

  vtf_top #(.WIDTH(10)) DUT (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .pix_word, .core_lock_indication, .pix_out, .h_flag, .v_flag, .f_flag,
    .lock_indication, .carrier_detect_input2, .loop_output_enable,
    .test_host_select, .loop_drive_en, .loop_serial_output_oe_n, .cs_tms_pin,
    .sclk_tck_pin, .shared_serial_in_pin, .shared_serial_out_pin,
    .shared_serial_out_oe_n, .host_cs_n, .host_sclk, .host_serial_in,
    .host_serial_out, .host_serial_out_en, .jtag_tms, .jtag_tck, .jtag_tdi,
    .jtag_tdo, .jtag_tdo_en);

  vtf_video_src src (.aclk, .aresetn, .field_two, .vert_blank, .signal_ok,
    .pix_word, .pos, .line_f, .line_v, .carrier_detect_input2);

  // Clock and run limit
  always #5 aclk = ~aclk;
  always @(posedge aclk) begin
    cycles++;
    if (cycles == TIMEOUT) begin
      failures++;
      final_report();
    end
  end

  // ----------------------------------------------------------------
  // Compare and report tasks
  // ----------------------------------------------------------------
  task automatic chk_bit(input string n, input logic e, input logic g);
    check_count++;
    if (g !== e) begin
      failures++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic chk_word(input string n, input logic [31:0] e,
                          input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      failures++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic chk_resp(input string n, input logic [1:0] e,
                          input logic [1:0] g);
    check_count++;
    if (g !== e) begin
      failures++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Register bus master
  // ----------------------------------------------------------------
  task automatic axi_write(input logic [3:0] a, input logic [31:0] d,
                           output logic [1:0] r);
    logic aw_left, w_left;
    aw_left = 1'h1;
    w_left = 1'h1;
    @(posedge aclk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid  <= 1'h1;
    s_axi_bready  <= 1'h1;
    while (aw_left || w_left) begin
      @(posedge aclk);
      if (aw_left && s_axi_awready) begin
        aw_left = 1'h0;
        s_axi_awvalid <= 1'h0;
      end
      if (w_left && s_axi_wready) begin
        w_left = 1'h0;
        s_axi_wvalid <= 1'h0;
      end
    end
    do @(posedge aclk); while (!s_axi_bvalid);
    r = s_axi_bresp;
    s_axi_bready <= 1'h0;
  endtask
  task automatic axi_read(input logic [3:0] a, output logic [31:0] d,
                          output logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready  <= 1'h1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'h0;
    do @(posedge aclk); while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'h0;
  endtask

  // Four field and blanking combinations, one line each, twice
  task automatic run_lines();
    for (int c = 0; c < 8; c++) begin
      field_two  <= c[1];
      vert_blank <= c[0];
      repeat (16) @(posedge aclk);
    end
  endtask

  // Flags and words checked against the source delayed by the pipe
  always @(negedge aclk) begin
    for (int i = PIPE; i > 0; i--)
      hist[i] = hist[i-1];
    hist[0] = {line_f, line_v, pos, pix_word};
    if (hist[PIPE][13:10] == 4'h0) begin
      exp_f = hist[PIPE][15];
      exp_v = hist[PIPE][14];
    end
    if (vid_on) begin
      if (h_mode)
        chk_bit("h_flag", hist[PIPE][13:10] < 4'h8, h_flag);
      else
        chk_bit("h_flag", hist[PIPE][13:10] < 4'hc, h_flag);
      chk_bit("v_flag", exp_v, v_flag);
      chk_bit("f_flag", exp_f, f_flag);
    end
    if (pix_on)
      chk_word("pix_out", muted ? 32'h0 : {22'h0, hist[PIPE][9:0]},
               {22'h0, pix_out});
  end

  // ----------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------
  initial begin : main
    logic [31:0] d;
    logic [1:0]  r;
    repeat (20) @(posedge aclk);
    aresetn <= 1'h1;
    axi_read(vtf_pkg::OFF_IO_PROC_DIS, d, r);
    chk_word("flag select reset", 32'h0, d);
    chk_resp("read resp", vtf_pkg::RESP_OKAY, r);
    repeat (8) @(posedge aclk);
    axi_read(vtf_pkg::OFF_STATUS, d, r);
    chk_word("status pins", 32'h3, {28'h0, d[3:0]});
    repeat (40) @(posedge aclk);
    vid_on = 1'h1;
    pix_on = 1'h1;
    run_lines();
    $display("test blanking mode finished");
    vid_on = 1'h0;
    axi_write(vtf_pkg::OFF_IO_PROC_DIS, 32'h1, r);
    chk_resp("write resp", vtf_pkg::RESP_OKAY, r);
    h_mode = 1'h1;
    axi_read(vtf_pkg::OFF_IO_PROC_DIS, d, r);
    chk_word("flag select", 32'h1, d);
    repeat (16) @(posedge aclk);
    vid_on = 1'h1;
    run_lines();
    axi_write(4'hc, 32'h0, r);
    chk_resp("unmapped write", vtf_pkg::RESP_DECERR, r);
    axi_read(4'hc, d, r);
    chk_resp("unmapped read", vtf_pkg::RESP_DECERR, r);
    chk_word("unmapped data", 32'h0, d);
    axi_read(vtf_pkg::OFF_IO_PROC_DIS, d, r);
    chk_word("select kept", 32'h1, d);
    s_axi_wstrb <= 4'he;
    axi_write(vtf_pkg::OFF_IO_PROC_DIS, 32'h0, r);
    s_axi_wstrb <= 4'hf;
    chk_resp("strobe off resp", vtf_pkg::RESP_OKAY, r);
    axi_read(vtf_pkg::OFF_IO_PROC_DIS, d, r);
    chk_word("strobe off kept", 32'h1, d);
    $display("test id bit mode finished");
    pix_on = 1'h0;
    signal_ok <= 1'h0;
    repeat (12) @(posedge aclk);
    muted = 1'h1;
    pix_on = 1'h1;
    repeat (32) @(posedge aclk);
    chk_bit("lock", 1'h0, lock_indication);
    axi_read(vtf_pkg::OFF_STATUS, d, r);
    chk_word("status muted", 32'h0, {30'h0, d[1:0]});
    pix_on = 1'h0;
    signal_ok <= 1'h1;
    repeat (12) @(posedge aclk);
    muted = 1'h0;
    pix_on = 1'h1;
    chk_bit("lock", 1'h1, lock_indication);
    core_lock_indication <= 1'h0;
    repeat (4) @(posedge aclk);
    chk_bit("lock", 1'h0, lock_indication);
    core_lock_indication <= 1'h1;
    $display("test carrier finished");
    for (int e = 1; e >= 0; e--) begin
      loop_output_enable <= e[0];
      repeat (6) @(posedge aclk);
      chk_bit("loop drive", e[0], loop_drive_en);
      chk_bit("loop oe_n", !e[0], loop_serial_output_oe_n);
    end
    $display("test loop output finished");
    for (int s = 0; s < 2; s++) begin
      test_host_select <= s[0];
      for (int p = 0; p < 8; p++) begin
        {cs_tms_pin, sclk_tck_pin, shared_serial_in_pin} <= p[2:0];
        {jtag_tdo, jtag_tdo_en} <= p[1:0];
        {host_serial_out, host_serial_out_en} <= ~p[1:0];
        repeat (6) @(posedge aclk);
        chk_word("host side", s ? 32'h7 : {29'h0, p[2:0]},
                 {29'h0, host_cs_n, host_sclk, host_serial_in});
        chk_word("jtag side", s ? {29'h0, p[2:0]} : 32'h7,
                 {29'h0, jtag_tms, jtag_tck, jtag_tdi});
        chk_word("out pin", s ? {30'h0, p[1], ~p[0]} : {30'h0, ~p[1], p[0]},
                 {30'h0, shared_serial_out_pin, shared_serial_out_oe_n});
      end
      axi_read(vtf_pkg::OFF_STATUS, d, r);
      chk_word("test mode", {31'h0, s[0]}, {31'h0, d[3]});
    end
    $display("test shared pins finished");
    final_report();
  end
endmodule
